//--- hw/scgr_global_regs.sv
// Global register bank with the two access ports and the region decode.
// Assumes requests held until acknowledged and core status inputs on sys_clk_i.
//
// Contract
// - Two-bit transmit clock source per quad, bits 0-1 and 4-5, 01=C, 11=D.
// - Two-bit receive clock source per quad, bits 2-3 and 6-7, 01=C, 11=D.
// - Threshold low three bits in second register bits 5-7, bit 5 least.
// - Threshold high two bits in third register bits 0-1, bit 1 most.
// - Rising edge of resync bit resynchronizes group; bit reset to zero.
// - Status bit 0 shows alignment FIFO overflow; zero after reset.
// - Status bit 1 shows alignment out of sync; zero after reset.
// - Registers are eight bits; status read-only, control read-write.
// - Decode 300xx, 301xx, 308xx, 309xx and 30A0x to their regions.
// - Processor address bits 14 to 31 form system address 17 to 0.
// - Fabric address bits 17 to 0 map directly to system address.
// - Thirty-two data plus four parity bits, bit n equals bit n.
// - Only data bits 0 to 7 are defined, field bits match.
`timescale 1ns/1ps
module scgr_global_regs (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Processor bus port
    input wire logic processor_bus_port_req_i,
    input wire logic processor_bus_port_we_i,
    input wire logic [0:31] processor_port_address_i,
    input wire logic [scgr_pkg::DATA_W-1:0] processor_bus_port_wdata_i,
    input wire logic [scgr_pkg::PAR_W-1:0] processor_bus_port_wpar_i,
    output logic processor_bus_port_ack_o,
    output logic [scgr_pkg::DATA_W-1:0] processor_bus_port_rdata_o,
    output logic [scgr_pkg::PAR_W-1:0] processor_bus_port_rpar_o,
    // Fabric master port
    input wire logic fabric_master_port_req_i,
    input wire logic fabric_master_port_we_i,
    input wire logic [scgr_pkg::SYS_AW-1:0] fabric_master_address_i,
    input wire logic [scgr_pkg::DATA_W-1:0] fabric_master_port_wdata_i,
    input wire logic [scgr_pkg::PAR_W-1:0] fabric_master_port_wpar_i,
    output logic fabric_master_port_ack_o,
    output logic [scgr_pkg::DATA_W-1:0] fabric_master_port_rdata_o,
    output logic [scgr_pkg::PAR_W-1:0] fabric_master_port_rpar_o,
    // Forwarded access to the other register regions
    output logic ext_req_o,
    output scgr_pkg::scgr_region_t ext_region_o,
    output scgr_pkg::scgr_req_t ext_cmd_o,
    input wire logic ext_ack_i,
    input wire logic [scgr_pkg::DATA_W-1:0] ext_rdata_i,
    input wire logic [scgr_pkg::PAR_W-1:0] ext_rpar_i,
    // Core controls and status
    output logic [1:0] tx_clock_source_quad_a_o,
    output logic [1:0] rx_clock_source_quad_a_o,
    output logic [1:0] tx_clock_source_quad_b_o,
    output logic [1:0] rx_clock_source_quad_b_o,
    output logic [4:0] rx_fifo_min_o,
    output logic group_resync_trigger_o,
    input wire logic group_align_overflow_i,
    input wire logic group_align_out_of_sync_i
);
    import scgr_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_EXT} scgr_state_t;

    // ----------------------------------------
    // Port selection and decode
    // ----------------------------------------
    scgr_req_t proc_req;
    scgr_req_t fab_req;
    scgr_req_t sel_req;
    scgr_region_t sel_region;
    logic [3:0] sel_idx;
    logic proc_take;
    logic fab_take;

    always_comb begin
        proc_req.we = processor_bus_port_we_i;
        proc_req.addr = processor_port_address_i[14:31];
        proc_req.wdata = processor_bus_port_wdata_i;
        proc_req.wpar = processor_bus_port_wpar_i;
        fab_req.we = fabric_master_port_we_i;
        fab_req.addr = fabric_master_address_i;
        fab_req.wdata = fabric_master_port_wdata_i;
        fab_req.wpar = fabric_master_port_wpar_i;
    end

    scgr_addr_decode u_decode (
        .addr_i(sel_req.addr),
        .region_o(sel_region),
        .reg_idx_o(sel_idx)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    scgr_state_t state_ff, nxt_state;
    logic owner_ff, nxt_owner;
    logic [7:0] clk_sel_ff, nxt_clk_sel;
    logic [7:0] thr_lo_ff, nxt_thr_lo;
    logic [7:0] thr_hi_ff, nxt_thr_hi;
    logic [7:0] status_ff, nxt_status;
    logic resync_pulse_ff, nxt_resync_pulse;
    logic proc_ack_ff, nxt_proc_ack;
    logic fab_ack_ff, nxt_fab_ack;
    scgr_rsp_t proc_rsp_ff, nxt_proc_rsp;
    scgr_rsp_t fab_rsp_ff, nxt_fab_rsp;
    logic ext_req_ff, nxt_ext_req;
    scgr_region_t ext_region_ff, nxt_ext_region;
    scgr_req_t ext_cmd_ff, nxt_ext_cmd;
    logic [7:0] rd_byte;
    scgr_rsp_t rsp;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        proc_take = 1'b0;
        fab_take = 1'b0;
        nxt_state = state_ff;
        nxt_owner = owner_ff;
        nxt_clk_sel = clk_sel_ff;
        nxt_thr_lo = thr_lo_ff;
        nxt_thr_hi = thr_hi_ff;
        nxt_proc_ack = 1'b0;
        nxt_fab_ack = 1'b0;
        nxt_proc_rsp = proc_rsp_ff;
        nxt_fab_rsp = fab_rsp_ff;
        nxt_ext_req = 1'b0;
        nxt_ext_region = ext_region_ff;
        nxt_ext_cmd = ext_cmd_ff;
        rd_byte = 8'h00;
        rsp.rdata = '0;
        rsp.rpar = '0;
        // Live core status, read-only
        nxt_status = 8'h00;
        nxt_status[OVFL_POS] = group_align_overflow_i;
        nxt_status[OOS_POS] = group_align_out_of_sync_i;
        // Processor port first, a port is skipped while its ack shows
        if (state_ff == ST_IDLE) begin
            proc_take = processor_bus_port_req_i && !proc_ack_ff;
            fab_take = !proc_take && fabric_master_port_req_i && !fab_ack_ff;
        end
        sel_req = proc_take ? proc_req : fab_req;
        unique case (state_ff)
            ST_IDLE: begin
                if (proc_take || fab_take) begin
                    nxt_owner = fab_take;
                    if (sel_region == RGN_GLOBAL) begin
                        unique case (sel_req.addr)
                            CLOCK_SOURCE_SELECT_OFS: begin
                                rd_byte = clk_sel_ff;
                                if (sel_req.we) begin
                                    nxt_clk_sel = sel_req.wdata[7:0] & CLK_SEL_MASK;
                                end
                            end
                            FIFO_THRESHOLD_LOW_BITS_OFS: begin
                                rd_byte = thr_lo_ff;
                                if (sel_req.we) begin
                                    nxt_thr_lo = sel_req.wdata[7:0] & THR_LO_MASK;
                                end
                            end
                            FIFO_THRESHOLD_HIGH_AND_RESYNC_OFS: begin
                                rd_byte = thr_hi_ff;
                                if (sel_req.we) begin
                                    nxt_thr_hi = sel_req.wdata[7:0] & THR_HI_MASK;
                                end
                            end
                            GROUP_ALIGNMENT_STATUS_OFS: begin
                                rd_byte = status_ff;
                            end
                            default: begin
                                rd_byte = 8'h00;
                            end
                        endcase
                        rsp.rdata = {24'h00_0000, rd_byte};
                        for (int i = 0; i < PAR_W; i++) begin
                            rsp.rpar[i] = ^rsp.rdata[8*i +: 8];
                        end
                        if (proc_take) begin
                            nxt_proc_ack = 1'b1;
                            nxt_proc_rsp = rsp;
                        end else begin
                            nxt_fab_ack = 1'b1;
                            nxt_fab_rsp = rsp;
                        end
                    end else if (sel_region == RGN_NONE) begin
                        // Unmapped address answers zero
                        nxt_proc_ack = proc_take;
                        nxt_fab_ack = fab_take;
                        if (proc_take) begin
                            nxt_proc_rsp = rsp;
                        end else begin
                            nxt_fab_rsp = rsp;
                        end
                    end else begin
                        nxt_ext_req = 1'b1;
                        nxt_ext_region = sel_region;
                        nxt_ext_cmd = sel_req;
                        nxt_state = ST_EXT;
                    end
                end
            end
            ST_EXT: begin
                if (ext_ack_i) begin
                    rsp.rdata = ext_rdata_i;
                    rsp.rpar = ext_rpar_i;
                    nxt_state = ST_IDLE;
                    if (owner_ff) begin
                        nxt_fab_ack = 1'b1;
                        nxt_fab_rsp = rsp;
                    end else begin
                        nxt_proc_ack = 1'b1;
                        nxt_proc_rsp = rsp;
                    end
                end
            end
        endcase
        // Pulse on a zero-to-one change of the resync bit
        nxt_resync_pulse = nxt_thr_hi[RESYNC_POS] && !thr_hi_ff[RESYNC_POS];
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            state_ff <= ST_IDLE;
            owner_ff <= 1'b0;
            clk_sel_ff <= CLOCK_SOURCE_SELECT_RST;
            thr_lo_ff <= FIFO_THRESHOLD_LOW_BITS_RST;
            thr_hi_ff <= FIFO_THRESHOLD_HIGH_AND_RESYNC_RST;
            status_ff <= GROUP_ALIGNMENT_STATUS_RST;
            resync_pulse_ff <= 1'b0;
            proc_ack_ff <= 1'b0;
            fab_ack_ff <= 1'b0;
            proc_rsp_ff <= '0;
            fab_rsp_ff <= '0;
            ext_req_ff <= 1'b0;
            ext_region_ff <= RGN_NONE;
            ext_cmd_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            owner_ff <= nxt_owner;
            clk_sel_ff <= nxt_clk_sel;
            thr_lo_ff <= nxt_thr_lo;
            thr_hi_ff <= nxt_thr_hi;
            status_ff <= nxt_status;
            resync_pulse_ff <= nxt_resync_pulse;
            proc_ack_ff <= nxt_proc_ack;
            fab_ack_ff <= nxt_fab_ack;
            proc_rsp_ff <= nxt_proc_rsp;
            fab_rsp_ff <= nxt_fab_rsp;
            ext_req_ff <= nxt_ext_req;
            ext_region_ff <= nxt_ext_region;
            ext_cmd_ff <= nxt_ext_cmd;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign processor_bus_port_ack_o = proc_ack_ff;
    assign processor_bus_port_rdata_o = proc_rsp_ff.rdata;
    assign processor_bus_port_rpar_o = proc_rsp_ff.rpar;
    assign fabric_master_port_ack_o = fab_ack_ff;
    assign fabric_master_port_rdata_o = fab_rsp_ff.rdata;
    assign fabric_master_port_rpar_o = fab_rsp_ff.rpar;
    assign ext_req_o = ext_req_ff;
    assign ext_region_o = ext_region_ff;
    assign ext_cmd_o = ext_cmd_ff;
    // Code reads with field bit 0 on the left, 01 picks channel C
    assign tx_clock_source_quad_a_o = {clk_sel_ff[TX_SRC_A_POS], clk_sel_ff[TX_SRC_A_POS+1]};
    assign rx_clock_source_quad_a_o = {clk_sel_ff[RX_SRC_A_POS], clk_sel_ff[RX_SRC_A_POS+1]};
    assign tx_clock_source_quad_b_o = {clk_sel_ff[TX_SRC_B_POS], clk_sel_ff[TX_SRC_B_POS+1]};
    assign rx_clock_source_quad_b_o = {clk_sel_ff[RX_SRC_B_POS], clk_sel_ff[RX_SRC_B_POS+1]};
    // Threshold: high bits 1 then 0, low bits 7 down to 5
    assign rx_fifo_min_o = {thr_hi_ff[FIFO_MIN_HI_POS+1], thr_hi_ff[FIFO_MIN_HI_POS],
                            thr_lo_ff[FIFO_MIN_LO_POS+2], thr_lo_ff[FIFO_MIN_LO_POS+1],
                            thr_lo_ff[FIFO_MIN_LO_POS]};
    assign group_resync_trigger_o = resync_pulse_ff;

endmodule // scgr_global_regs

//--- pkg/scgr_pkg.sv
// Package for the global control and status register bank of the serializer core.
// Assumes one 100 MHz system clock and a synchronous active-low reset.
package scgr_pkg;

    // ----------------------------------------
    // System address space
    // ----------------------------------------
    localparam int SYS_AW = 18;
    localparam int DATA_W = 32;
    localparam int PAR_W = 4;
    localparam int REG_W = 8;

    // Region prefixes, upper address bits [17:8]
    localparam logic [9:0] PFX_QUAD_A_INT = 10'h300;
    localparam logic [9:0] PFX_QUAD_B_INT = 10'h301;
    localparam logic [9:0] PFX_CHAN_A = 10'h308;
    localparam logic [9:0] PFX_CHAN_B = 10'h309;
    // Global region prefix, upper address bits [17:4]
    localparam logic [13:0] PFX_GLOBAL = 14'h30a0;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [17:0] CLOCK_SOURCE_SELECT_OFS = 18'h3_0a00;
    localparam logic [17:0] FIFO_THRESHOLD_LOW_BITS_OFS = 18'h3_0a01;
    localparam logic [17:0] FIFO_THRESHOLD_HIGH_AND_RESYNC_OFS = 18'h3_0a02;
    localparam logic [17:0] GROUP_ALIGNMENT_STATUS_OFS = 18'h3_0a03;

    // ----------------------------------------
    // Field positions, data bit n is field bit n
    // ----------------------------------------
    localparam int TX_SRC_A_POS = 0;
    localparam int RX_SRC_A_POS = 2;
    localparam int TX_SRC_B_POS = 4;
    localparam int RX_SRC_B_POS = 6;
    localparam int FIFO_MIN_LO_POS = 5;
    localparam int FIFO_MIN_HI_POS = 0;
    localparam int RESYNC_POS = 2;
    localparam int OVFL_POS = 0;
    localparam int OOS_POS = 1;

    // Writable bit masks
    localparam logic [7:0] CLK_SEL_MASK = 8'hff;
    localparam logic [7:0] THR_LO_MASK = 8'he0;
    localparam logic [7:0] THR_HI_MASK = 8'h07;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] CLOCK_SOURCE_SELECT_RST = 8'h00;
    localparam logic [7:0] FIFO_THRESHOLD_LOW_BITS_RST = 8'h00;
    localparam logic [7:0] FIFO_THRESHOLD_HIGH_AND_RESYNC_RST = 8'h00;
    localparam logic [7:0] GROUP_ALIGNMENT_STATUS_RST = 8'h00;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {
        RGN_NONE,
        RGN_QUAD_A_INT,
        RGN_QUAD_B_INT,
        RGN_CHAN_A,
        RGN_CHAN_B,
        RGN_GLOBAL
    } scgr_region_t;

    typedef struct packed {
        logic we;
        logic [SYS_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [PAR_W-1:0] wpar;
    } scgr_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic [PAR_W-1:0] rpar;
    } scgr_rsp_t;

endpackage

//--- hw/scgr_addr_decode.sv
// Address decoder of the 18-bit system register space.
// Assumes a stable address while a request is presented.
`timescale 1ns/1ps
module scgr_addr_decode (
    input wire logic [scgr_pkg::SYS_AW-1:0] addr_i,
    output scgr_pkg::scgr_region_t region_o,
    output logic [3:0] reg_idx_o
);
    import scgr_pkg::*;

    // ----------------------------------------
    // Region decode
    // ----------------------------------------
    always_comb begin
        reg_idx_o = addr_i[3:0];
        region_o = RGN_NONE;
        if (addr_i[17:4] == PFX_GLOBAL) begin
            region_o = RGN_GLOBAL;
        end else if (addr_i[17:8] == PFX_QUAD_A_INT) begin
            region_o = RGN_QUAD_A_INT;
        end else if (addr_i[17:8] == PFX_QUAD_B_INT) begin
            region_o = RGN_QUAD_B_INT;
        end else if (addr_i[17:8] == PFX_CHAN_A) begin
            region_o = RGN_CHAN_A;
        end else if (addr_i[17:8] == PFX_CHAN_B) begin
            region_o = RGN_CHAN_B;
        end
    end

endmodule // scgr_addr_decode

//--- sim/scgr_ext_model.sv
// Model of the register regions reached through the forwarding port.
// Assumes one forward at a time; answers alternate between prompt and slow.
`timescale 1ns/1ps
module scgr_ext_model (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic ext_req_i,
    input wire scgr_pkg::scgr_req_t ext_cmd_i,
    output logic ext_ack_o,
    output logic [31:0] ext_rdata_o,
    output logic [3:0] ext_rpar_o
);
    import scgr_pkg::*;
    logic busy, slow;
    int cnt;
    // ----------------------------------------
    // Delayed answer, data made from address
    // ----------------------------------------
    always @(posedge sys_clk_i) begin
        ext_ack_o <= 1'b0;
        ext_rdata_o <= ~ext_rdata_o;
        ext_rpar_o <= ~ext_rpar_o;
        if (!reset_n_i) begin
            busy <= 1'b0;
            slow <= 1'b0;
            ext_rdata_o <= 32'h5a5a_a5a5;
            ext_rpar_o <= 4'h5;
        end else if (ext_req_i) begin
            busy <= 1'b1;
            slow <= ~slow;
            cnt <= slow ? 12 : 0;
        end else if (busy && cnt == 0) begin
            busy <= 1'b0;
            ext_ack_o <= 1'b1;
            ext_rdata_o <= {14'h0, ext_cmd_i.addr};
            ext_rpar_o <= ext_cmd_i.addr[3:0];
        end else if (busy) begin
            cnt <= cnt - 1;
        end
    end
endmodule // scgr_ext_model

//--- sim/scgr_global_regs_asserts.sv
// Checker for the global register bank ports.
// Assumes binding onto scgr_global_regs with matching port names.
`timescale 1ns/1ps
module scgr_global_regs_asserts (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic processor_bus_port_we_i,
    input wire logic [0:31] processor_port_address_i,
    input wire logic [31:0] processor_bus_port_wdata_i,
    input wire logic processor_bus_port_ack_o,
    input wire logic [31:0] processor_bus_port_rdata_o,
    input wire logic [3:0] processor_bus_port_rpar_o,
    input wire logic fabric_master_port_ack_o,
    input wire logic ext_req_o,
    input wire scgr_pkg::scgr_region_t ext_region_o,
    input wire scgr_pkg::scgr_req_t ext_cmd_o,
    input wire logic ext_ack_i,
    input wire logic [31:0] ext_rdata_i,
    input wire logic [1:0] tx_clock_source_quad_a_o,
    input wire logic [1:0] rx_clock_source_quad_a_o,
    input wire logic [1:0] tx_clock_source_quad_b_o,
    input wire logic [1:0] rx_clock_source_quad_b_o,
    input wire logic [4:0] rx_fifo_min_o,
    input wire logic group_resync_trigger_o,
    input wire logic group_align_overflow_i,
    input wire logic group_align_out_of_sync_i
);
    import scgr_pkg::*;
    logic [17:0] a;
    logic [7:0] d;
    logic ca, cw;
    logic [31:0] q;
    assign a = processor_port_address_i[14:31];
    assign d = processor_bus_port_wdata_i[7:0];
    assign ca = processor_bus_port_ack_o;
    assign cw = ca && processor_bus_port_we_i;
    assign q = processor_bus_port_rdata_o;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    function automatic scgr_region_t rgn(input logic [17:0] x);
        if (x[17:8] == 10'h300) return RGN_QUAD_A_INT;
        if (x[17:8] == 10'h301) return RGN_QUAD_B_INT;
        if (x[17:8] == 10'h308) return RGN_CHAN_A;
        if (x[17:8] == 10'h309) return RGN_CHAN_B;
        return RGN_NONE;
    endfunction
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_fwd_done;
        ext_ack_i ##1 ca;
    endsequence
    property p_sel;
        cw && a == 18'h3_0a00 |-> {tx_clock_source_quad_a_o, rx_clock_source_quad_a_o, tx_clock_source_quad_b_o,
            rx_clock_source_quad_b_o} == {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]};
    endproperty
    a_sel: assert property (p_sel) else $error("clock select wrong");
    property p_thr_lo;
        cw && a == 18'h3_0a01 |-> rx_fifo_min_o[2:0] == d[7:5];
    endproperty
    a_thr_lo: assert property (p_thr_lo) else $error("threshold low wrong");
    property p_thr_hi;
        cw && a == 18'h3_0a02 |-> rx_fifo_min_o[4:3] == d[1:0];
    endproperty
    a_thr_hi: assert property (p_thr_hi) else $error("threshold high wrong");
    property p_resync;
        $rose(group_resync_trigger_o) |-> (ca || fabric_master_port_ack_o) ##1 !group_resync_trigger_o;
    endproperty
    a_resync: assert property (p_resync) else $error("resync pulse wrong");
    property p_status;
        ca && !processor_bus_port_we_i && a == 18'h3_0a03 |->
            q == {30'h0, $past(group_align_out_of_sync_i, 2), $past(group_align_overflow_i, 2)};
    endproperty
    a_status: assert property (p_status) else $error("status read wrong");
    property p_upper;
        ca && a[17:4] == 14'h30a0 |-> q[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_par;
        ca && a[17:4] == 14'h30a0 |-> processor_bus_port_rpar_o == {^q[31:24], ^q[23:16], ^q[15:8], ^q[7:0]};
    endproperty
    a_par: assert property (p_par) else $error("read parity wrong");
    property p_decode;
        ext_req_o |-> ext_region_o == rgn(ext_cmd_o.addr) && ext_region_o != RGN_NONE;
    endproperty
    a_decode: assert property (p_decode) else $error("forward region wrong");
    property p_fwd_data;
        s_fwd_done |-> q == $past(ext_rdata_i);
    endproperty
    a_fwd_data: assert property (p_fwd_data) else $error("forward data wrong");
    property p_ack;
        ca |=> !ca;
    endproperty
    a_ack: assert property (p_ack) else $error("ack longer than one cycle");
endmodule // scgr_global_regs_asserts

bind scgr_global_regs scgr_global_regs_asserts u_scgr_global_regs_asserts (.*);

//--- sim/scgr_global_regs_test.sv
// Testbench for the global register bank.
// Assumes the design, its checker and the region model compile alongside.
`timescale 1ns/1ps
module scgr_global_regs_test;
    import scgr_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic sys_clk_i, reset_n_i, trg;
    logic processor_bus_port_req_i, processor_bus_port_we_i, processor_bus_port_ack_o;
    logic [0:31] processor_port_address_i;
    logic [31:0] processor_bus_port_wdata_i, processor_bus_port_rdata_o, fabric_master_port_wdata_i;
    logic [3:0] processor_bus_port_wpar_i, processor_bus_port_rpar_o, fabric_master_port_wpar_i;
    logic fabric_master_port_req_i, fabric_master_port_we_i, fabric_master_port_ack_o;
    logic [17:0] fabric_master_address_i;
    logic [31:0] fabric_master_port_rdata_o, ext_rdata_i, rd;
    logic [3:0] fabric_master_port_rpar_o, ext_rpar_i, rp;
    logic ext_req_o, ext_ack_i, group_resync_trigger_o, group_align_overflow_i, group_align_out_of_sync_i;
    scgr_region_t ext_region_o;
    scgr_req_t ext_cmd_o;
    logic [1:0] tx_clock_source_quad_a_o, rx_clock_source_quad_a_o, tx_clock_source_quad_b_o, rx_clock_source_quad_b_o;
    logic [4:0] rx_fifo_min_o;
    int err_count = 0, comparisons = 0;
    logic [7:0] sw [3] = '{8'haa, 8'hff, 8'h55};
    logic [7:0] se [3] = '{8'h55, 8'hff, 8'haa};
    logic [17:0] fa [4] = '{18'h3_0012, 18'h3_0100, 18'h3_0805, 18'h3_0933};
    scgr_region_t fr [4] = '{RGN_QUAD_A_INT, RGN_QUAD_B_INT, RGN_CHAN_A, RGN_CHAN_B};
    scgr_global_regs u_scgr_global_regs (.*);
    scgr_ext_model u_scgr_ext_model (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .ext_req_i(ext_req_o),
        .ext_cmd_i(ext_cmd_o),
        .ext_ack_o(ext_ack_i),
        .ext_rdata_o(ext_rdata_i),
        .ext_rpar_o(ext_rpar_i)
    );
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic complete_run();
        if (err_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(input bit p, input bit we, input logic [17:0] ad, input logic [31:0] wd);
        int i;
        @(posedge sys_clk_i);
        if (p) begin
            fabric_master_port_req_i <= 1'b1;
            fabric_master_port_we_i <= we;
            fabric_master_address_i <= ad;
            fabric_master_port_wdata_i <= wd;
            fabric_master_port_wpar_i <= wd[3:0];
        end else begin
            processor_bus_port_req_i <= 1'b1;
            processor_bus_port_we_i <= we;
            processor_port_address_i <= {14'h2a5a, ad};
            processor_bus_port_wdata_i <= wd;
            processor_bus_port_wpar_i <= wd[3:0];
        end
        for (i = 0; i < 100; i++) begin
            @(negedge sys_clk_i);
            if ((p ? fabric_master_port_ack_o : processor_bus_port_ack_o) === 1'b1) break;
        end
        if (i == 100) begin
            err_count++;
            complete_run();
        end
        rd = p ? fabric_master_port_rdata_o : processor_bus_port_rdata_o;
        rp = p ? fabric_master_port_rpar_o : processor_bus_port_rpar_o;
        trg = group_resync_trigger_o;
        @(posedge sys_clk_i);
        if (p) fabric_master_port_req_i <= 1'b0;
        else processor_bus_port_req_i <= 1'b0;
    endtask
    task automatic rdc(input bit p, input logic [17:0] ad, input logic [31:0] e);
        acc(p, 1'b0, ad, 32'h0);
        chk("rdata", e, rd);
        chk("rpar", {28'h0, ^e[31:24], ^e[23:16], ^e[15:8], ^e[7:0]}, {28'h0, rp});
    endtask
    task automatic chk_reset();
        for (int i = 0; i < 3; i++) rdc(i[0], 18'h3_0a00 + 18'(i), 32'h0);
        chk("outputs", 32'h0, {16'h0, tx_clock_source_quad_a_o, rx_clock_source_quad_a_o, tx_clock_source_quad_b_o,
            rx_clock_source_quad_b_o, rx_fifo_min_o, group_resync_trigger_o, ext_req_o, 1'b0});
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {processor_bus_port_req_i, processor_bus_port_we_i, fabric_master_port_req_i, fabric_master_port_we_i} = 4'h0;
        {processor_port_address_i, processor_bus_port_wdata_i, processor_bus_port_wpar_i} = 68'h0;
        {fabric_master_address_i, fabric_master_port_wdata_i, fabric_master_port_wpar_i} = 54'h0;
        {group_align_overflow_i, group_align_out_of_sync_i, reset_n_i} = 3'h0;
        repeat (16) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        chk_reset();
        for (int j = 0; j < 3; j++) begin
            acc(j[0], 1'b1, 18'h3_0a00, {24'hab_cdef, sw[j]});
            chk("clock select", {24'h0, se[j]}, {24'h0, tx_clock_source_quad_a_o, rx_clock_source_quad_a_o,
                tx_clock_source_quad_b_o, rx_clock_source_quad_b_o});
            rdc(~j[0], 18'h3_0a00, {24'h0, sw[j]});
        end
        acc(0, 1'b1, 18'h3_0a01, 32'hffff_ffff);
        rdc(0, 18'h3_0a01, 32'he0);
        for (int v = 0; v < 18; v++) begin
            acc(v[0], 1'b1, 18'h3_0a01, {24'h0, v[2:0], 5'h1f});
            acc(0, 1'b1, 18'h3_0a02, {30'h0, v[4:3]});
            chk("threshold", 32'(v), {27'h0, rx_fifo_min_o});
        end
        acc(0, 1'b1, 18'h3_0a02, 32'h4);
        chk("trigger", 32'h1, {31'h0, trg});
        acc(1, 1'b1, 18'h3_0a02, 32'hfc);
        chk("trigger", 32'h0, {31'h0, trg});
        rdc(0, 18'h3_0a02, 32'h4);
        acc(0, 1'b1, 18'h3_0a02, 32'h0);
        acc(1, 1'b1, 18'h3_0a02, 32'h4);
        chk("trigger", 32'h1, {31'h0, trg});
        for (int k = 0; k < 4; k++) begin
            group_align_overflow_i <= k[0];
            group_align_out_of_sync_i <= k[1];
            repeat (3) @(posedge sys_clk_i);
            rdc(k[0], 18'h3_0a03, {30'h0, k[1:0]});
        end
        acc(0, 1'b1, 18'h3_0a03, 32'h0);
        rdc(0, 18'h3_0a03, 32'h3);
        rdc(0, 18'h3_0a04, 32'h0);
        rdc(1, 18'h0_1234, 32'h0);
        for (int i = 0; i < 4; i++) begin
            acc(i[1], 1'b0, fa[i], 32'h0);
            chk("fwd rdata", {14'h0, fa[i]}, rd);
            chk("fwd rpar", {28'h0, fa[i][3:0]}, {28'h0, rp});
            chk("region", {29'h0, fr[i]}, {29'h0, ext_region_o});
        end
        acc(0, 1'b1, 18'h3_0805, 32'h1234_5678);
        chk("fwd wdata", 32'h1234_5678, ext_cmd_o.wdata);
        chk("fwd cmd", {13'h1, 18'h3_0805, 1'b1}, {12'h0, ext_cmd_o.wpar == 4'h8, ext_cmd_o.addr, ext_cmd_o.we});
        fork
            acc(0, 1'b1, 18'h3_0a00, 32'h33);
            acc(1, 1'b0, 18'h3_0a00, 32'h0);
        join
        chk("order", 32'h33, rd);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        chk_reset();
        complete_run();
    end
endmodule // scgr_global_regs_test
